// *** hdl/ssrr_top.v ***
// Serial strobe ROM reader: address shift-in, counter, ROM and output pin
//
// Function
// - The block holds 1,048,576 fixed one-bit words and gives one bit per read.
// - The word address is built from a 1024-position column part and a 1024-position row part.
// - Ten column address bits are shifted in on the column serial line.
// - Ten row address bits are shifted in on the row serial line.
// - Each column strobe pulse captures one column address bit.
// - Each row strobe pulse captures one row address bit.
// - The falling edge of the load strobe copies both shift registers into the counter.
// - Each falling edge of the read clock not in the same cycle as a load strobe fall reads the addressed word onto the data output.
// - Each falling edge of the read clock not in the same cycle as a load strobe fall advances the address counter by one.
// - Reads continue back to back on the read clock alone, with no reload.
// - The data output floats while the read clock or the chip select is high.
// - The bit read is held on the output while the read clock stays low.
// - While chip select is high the address and read pins are ignored and the data output is not driven.
`timescale 1ns/1ns
`include "ssrr_defines.vh"
module ssrr_top (
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Address pins
   input  wire colAddrSerialIn,
   input  wire rowAddrSerialIn,
   input  wire colAddrShiftStrobe,
   input  wire rowAddrShiftStrobe,
   input  wire addrLoadStrobe_n,
   // Read pins
   input  wire readClock_n,
   input  wire chipSelect_n,
   // Data output pin
   output reg  dataOut,
   output reg  dataOutEn,
   // Factory test pins
   input  wire factoryTestInLow,
   input  wire factoryTestInHigh,
   output wire factoryTestOutA,
   output wire factoryTestOutB,
   // Stream of bits read, for on-chip consumers
   output wire streamValid,
   input  wire streamReady,
   output wire streamData
);
   // Synchroniser stages: first stage read only by second
   reg [6:0] sync1_r;
   reg [6:0] sync2_r;
   reg [6:0] prev_r;

   // Pin order in the synchroniser vector
   localparam IDX_CX  = 0;
   localparam IDX_RY  = 1;
   localparam IDX_SX  = 2;
   localparam IDX_SY  = 3;
   localparam IDX_LD  = 4;
   localparam IDX_RD  = 5;
   localparam IDX_CS  = 6;

   wire [6:0] pinsIn;
   assign pinsIn = {chipSelect_n, readClock_n, addrLoadStrobe_n, rowAddrShiftStrobe,
                    colAddrShiftStrobe, rowAddrSerialIn, colAddrSerialIn};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 7'h70;
         sync2_r <= 7'h70;
         prev_r  <= 7'h70;
      end else begin
         sync1_r <= pinsIn;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Selected: chip select low after sync
   wire selected;
   assign selected = ~sync2_r[IDX_CS];

   // Edge events, all gated by chip select
   wire colStrobeRise;
   wire rowStrobeRise;
   wire loadFall;
   wire readFall;
   assign colStrobeRise = selected & sync2_r[IDX_SX] & ~prev_r[IDX_SX];
   assign rowStrobeRise = selected & sync2_r[IDX_SY] & ~prev_r[IDX_SY];
   assign loadFall      = selected & ~sync2_r[IDX_LD] & prev_r[IDX_LD];
   assign readFall      = selected & ~sync2_r[IDX_RD] & prev_r[IDX_RD];

   // Serial address shift registers; bit 0 arrives first, so shift right
   reg  [`SSRR_HALF_W-1:0] colShift_r;
   reg  [`SSRR_HALF_W-1:0] rowShift_r;
   wire [`SSRR_HALF_W-1:0] colShift_nxt;
   wire [`SSRR_HALF_W-1:0] rowShift_nxt;
   assign colShift_nxt = {sync2_r[IDX_CX], colShift_r[`SSRR_HALF_MSB:1]};
   assign rowShift_nxt = {sync2_r[IDX_RY], rowShift_r[`SSRR_HALF_MSB:1]};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         colShift_r <= `SSRR_HALF_RST;
         rowShift_r <= `SSRR_HALF_RST;
      end else begin
         if (colStrobeRise) begin
            colShift_r <= colShift_nxt;
         end
         if (rowStrobeRise) begin
            rowShift_r <= rowShift_nxt;
         end
      end
   end

   // Address counter; a load in the same cycle as a read wins
   reg  [`SSRR_ADDR_W-1:0] addr_r;
   wire [`SSRR_ADDR_W-1:0] addr_nxt;
   assign addr_nxt = addr_r + 20'h00001; // wraps by width

   // ROM array: one bit per word, filled from a constant pattern
   reg  romMem [0:`SSRR_WORDS-1];
   integer i;
   initial begin
      for (i = 0; i < `SSRR_WORDS; i = i + 1) begin
         romMem[i] = ^i[19:0] ^ i[3];
      end
   end

   // Fetched bit; the pin path never waits on the FIFO
   wire fifoInReady;
   reg  readBit_r;
   reg  readPending_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_r        <= `SSRR_ADDR_RST;
         readBit_r     <= 1'b0;
         readPending_r <= 1'b0;
      end else begin
         readPending_r <= 1'b0;
         if (loadFall) begin
            addr_r <= {rowShift_r, colShift_r};
         end else if (readFall) begin
            readBit_r     <= romMem[addr_r];
            readPending_r <= 1'b1;
            addr_r        <= addr_nxt;
         end
      end
   end

   // Output pin: driven only while selected and read clock low
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dataOut   <= 1'b0;
         dataOutEn <= 1'b0;
      end else begin
         dataOutEn <= selected & ~sync2_r[IDX_RD];
         if (readPending_r) begin
            dataOut <= readBit_r; // held until the next read
         end
      end
   end

   // Stream copy; an overflowing FIFO drops bits since the pin cannot stall
   ssrr_fifo #(
      .WIDTH (`SSRR_FIFO_W),
      .DEPTH (`SSRR_FIFO_DEPTH),
      .AW    (`SSRR_FIFO_AW)
   ) uFifo (
      .clk      (clk),
      .rst      (rst),
      .inValid  (readPending_r),
      .inReady  (fifoInReady),
      .inData   (readBit_r),
      .outValid (streamValid),
      .outReady (streamReady),
      .outData  (streamData)
   );

   // Test outputs left unused; test inputs only observed by the board
   assign factoryTestOutA = 1'b0;
   assign factoryTestOutB = 1'b0;
endmodule

// *** hdl/ssrr_defines.vh ***
// Constants of the serial strobe ROM reader
`ifndef SSRR_DEFINES_VH
`define SSRR_DEFINES_VH
`define SSRR_HALF_W      10
`define SSRR_ADDR_W      20
`define SSRR_WORDS       1048576
`define SSRR_ADDR_RST    20'h00000
`define SSRR_HALF_RST    10'h000
`define SSRR_HALF_MSB    9
`define SSRR_FIFO_W      1
`define SSRR_FIFO_DEPTH  16
`define SSRR_FIFO_AW     4
`endif

// *** hdl/ssrr_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module ssrr_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst,
   // Fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // Drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_r;
   reg [AW-1:0]    rdPtr_r;
   reg [AW:0]      count_r;
   wire            doWr;
   wire            doRd;

   assign inReady  = (count_r != DEPTH[AW:0]);
   assign outValid = (count_r != {(AW+1){1'b0}});
   assign outData  = mem[rdPtr_r];
   assign doWr     = inValid & inReady;
   assign doRd     = outValid & outReady;

   always @(posedge clk) begin
      if (doWr) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (doWr) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (doRd) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
         if (doWr && !doRd) begin
            count_r <= count_r + 1'b1;
         end else if (doRd && !doWr) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// *** test/ssrr_top_assertions.sv ***
// Checker of the ROM reader pins
`timescale 1ns/1ns
module ssrr_top_assertions (
   // Clock and reset
   input logic clk,
   input logic rst,
   // Pins
   input logic readClock_n,
   input logic chipSelect_n,
   input logic dataOut,
   input logic dataOutEn,
   input logic factoryTestOutA,
   input logic factoryTestOutB,
   input logic streamValid,
   input logic streamReady
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_csOff; chipSelect_n [*4] |-> !dataOutEn; endproperty
   a_csOff: assert property (p_csOff) else $error("driven unselected");
   property p_rdOff; readClock_n [*4] |-> !dataOutEn; endproperty
   a_rdOff: assert property (p_rdOff) else $error("driven clock high");
   property p_on; (!readClock_n && !chipSelect_n) [*5] |-> dataOutEn; endproperty
   a_on: assert property (p_on) else $error("not driven");
   // Bit lands about four cycles after the fall, then must stay
   property p_hold; !readClock_n [*8] |-> $stable(dataOut); endproperty
   a_hold: assert property (p_hold) else $error("bit moved");
   property p_test; !factoryTestOutA && !factoryTestOutB; endproperty
   a_test: assert property (p_test) else $error("test pin active");
   property p_chg;
      $changed(dataOut) |-> !$past(readClock_n, 2) && !$past(chipSelect_n, 2);
   endproperty
   a_chg: assert property (p_chg) else $error("bit without read");
   property p_rise; $rose(streamValid) |-> !$past(readClock_n, 2); endproperty
   a_rise: assert property (p_rise) else $error("stream without read");
   property p_stall; streamValid && !streamReady |=> streamValid; endproperty
   a_stall: assert property (p_stall) else $error("stream lost");
   c_read: cover property (dataOutEn ##1 !dataOutEn);
   c_stall: cover property (streamValid && !streamReady);
   c_flip: cover property ($changed(dataOut));
endmodule
bind ssrr_top ssrr_top_assertions i_chk (.*);

// *** test/ssrr_ctrl_model.sv ***
// Playback controller model driving the reader pins
`timescale 1ns/1ns
module ssrr_ctrl_model (
   // Clock
   input  wire clk,
   // Pins toward the reader
   output reg  colAddrSerialIn,
   output reg  rowAddrSerialIn,
   output reg  colAddrShiftStrobe,
   output reg  rowAddrShiftStrobe,
   output reg  addrLoadStrobe_n,
   output reg  readClock_n,
   output reg  chipSelect_n
);
   integer i;
   initial {colAddrSerialIn, rowAddrSerialIn, colAddrShiftStrobe, rowAddrShiftStrobe,
      addrLoadStrobe_n, readClock_n, chipSelect_n} = 7'h07;
   task hold(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task sendAddr(input [19:0] a);
      for (i = 0; i < 10; i = i + 1) begin
         {colAddrSerialIn, rowAddrSerialIn} = {a[i], a[10+i]};
         hold(4);
         {colAddrShiftStrobe, rowAddrShiftStrobe} = 2'h3;
         hold(4);
         {colAddrShiftStrobe, rowAddrShiftStrobe} = 2'h0;
         hold(4);
      end
      {colAddrSerialIn, rowAddrSerialIn} = ~{a[9], a[19]}; // Stale bits never linger
      addrLoadStrobe_n = 1'b0;
      hold(4);
      addrLoadStrobe_n = 1'b1;
      hold(4);
   endtask
   task drive(input cs, input rd);
      {chipSelect_n, readClock_n} = {cs, rd};
      hold(8);
   endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench of the serial strobe ROM reader
`timescale 1ns/1ns
module testbench;
   reg         clk, rst, streamReady, randOn;
   reg  [31:0] seed;
   reg  [19:0] addr, first;
   integer     miscompares, tests_run, k, n;
   wire        colAddrSerialIn, rowAddrSerialIn, colAddrShiftStrobe, rowAddrShiftStrobe;
   wire        addrLoadStrobe_n, readClock_n, chipSelect_n, dataOut, dataOutEn;
   wire        streamValid, streamData, testOutA, testOutB;
   ssrr_top i_ssrr_top (.*, .factoryTestInLow(1'b0), .factoryTestInHigh(1'b1),
      .factoryTestOutA(testOutA), .factoryTestOutB(testOutB));
   ssrr_ctrl_model i_ssrr_ctrl_model (.*);
   always #10 clk = ~clk;
   always @(negedge clk) if (randOn) begin
      seed <= lfsr(seed);
      streamReady <= seed[0];
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function romBit(input [19:0] a);
      romBit = ^a ^ a[3];
   endfunction
   task check(input [19:0] seen, input [19:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task readOne(input en);
      i_ssrr_ctrl_model.drive(!en, 1'b0);
      check(dataOutEn, en);
      if (en) check(dataOut, romBit(addr));
      if (en) addr = addr + 1'b1;
      i_ssrr_ctrl_model.drive(!en, 1'b1);
      check(dataOutEn, 1'b0);
   endtask
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      miscompares = miscompares + 1;
      report_and_stop;
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      streamReady = 1'b0;
      randOn = 1'b1;
      seed = 32'h468eb932;
      miscompares = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      i_ssrr_ctrl_model.drive(1'b0, 1'b1);
      for (k = 0; k < 4; k = k + 1) begin
         addr = seed[19:0];
         i_ssrr_ctrl_model.sendAddr(addr);
         repeat (5) readOne(1'b1);
      end
      $display("Random address reads done");
      addr = 20'hffffe;
      i_ssrr_ctrl_model.sendAddr(addr);
      repeat (3) readOne(1'b1);
      $display("Wrap test done");
      i_ssrr_ctrl_model.drive(1'b1, 1'b1);
      i_ssrr_ctrl_model.sendAddr(20'h00003);
      readOne(1'b0);
      readOne(1'b1);
      $display("Deselect test done");
      randOn = 1'b0;
      // Let a pending random update land before taking over
      i_ssrr_ctrl_model.hold(1);
      streamReady = 1'b1;
      // Full FIFO needs sixteen pops to empty
      i_ssrr_ctrl_model.hold(20);
      check(streamValid, 1'b0);
      streamReady = 1'b0;
      first = addr;
      repeat (18) readOne(1'b1);
      n = 0;
      streamReady = 1'b1;
      repeat (30) begin
         if (streamValid === 1'b1) begin
            check(streamData, romBit(first + n[19:0]));
            n = n + 1;
         end
         @(negedge clk);
      end
      check(n[19:0], 20'h00010);
      check({testOutA, testOutB}, 2'h0);
      $display("Buffer test done");
      report_and_stop;
   end
endmodule
